// [hdl/ambient_light_measure_config.sv]
`include "ambient_light_cfg.svh"

// Summary of operation
// - light parameter settings live in one 8-bit register at address 84h.
// - bit 7 selects continuous conversion, read/write, resets to 0.
// - bit 3 enables offset compensation, read/write, resets to 1.
// - with compensation on, offset is measured before each reading and subtracted.
// - bits 2..0 set how many conversions one measurement cycle performs.
// - conversions equal two to the field value; reset value gives 32.
// - the stored result is the mean of all conversions in the cycle.
// - host sets the trigger bit; device runs one measurement sequence.
// - 16-bit result: high byte at 85h, low byte at 86h.
module ambient_light_measure_config #(
    parameter int SAMPLE_W = 16,
    parameter int AVG_W = 3,
    parameter int CNT_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register access
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    // converter
    output logic convStart,
    output logic convOffset,
    input wire logic convDone,
    input wire logic [SAMPLE_W-1:0] convData
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [CNT_W-1:0] convCount(input logic [AVG_W-1:0] avg);
        convCount = CNT_W'(1) << avg;
    endfunction

    function automatic logic [SAMPLE_W-1:0] offsetCorrect(
        input logic [SAMPLE_W-1:0] raw,
        input logic [SAMPLE_W-1:0] off,
        input logic en
    );
        // clamp at zero: a noisy offset above the reading must not wrap
        if (!en) begin
            offsetCorrect = raw;
        end else if (raw > off) begin
            offsetCorrect = raw - off;
        end else begin
            offsetCorrect = '0;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register decode

    logic [7:0] paramReg;
    logic [SAMPLE_W-1:0] lightResult;
    logic lightDataReady;
    ambient_light_pkg::light_state_t state;
    ambient_light_pkg::light_state_t next_state;

    wire cmdSel = (regAddr == `LIGHT_CMD_ADDR);
    wire paramSel = (regAddr == `LIGHT_PARAM_ADDR);
    wire resHiSel = (regAddr == `LIGHT_RES_HI_ADDR);
    wire resLoSel = (regAddr == `LIGHT_RES_LO_ADDR);
    wire paramWrite = regWrite && paramSel;
    wire idle = (state == ambient_light_pkg::ST_IDLE);
    wire busy = !idle;
    wire contMode = paramReg[`LIGHT_CONT_BIT];
    wire lightSingleShotTrigger = regWrite && cmdSel && regWrData[`LIGHT_TRIG_BIT];
    // a trigger while busy is dropped; the running sequence is not restarted
    wire startReq = idle && (lightSingleShotTrigger || contMode);

    logic [7:0] cmdView;
    logic [7:0] next_rdData;

    always_comb begin
        cmdView = 8'h00;
        cmdView[`LIGHT_READY_BIT] = lightDataReady;
        cmdView[`LIGHT_TRIG_BIT] = busy;
    end

    assign next_rdData = !regRead ? regRdData :
                         cmdSel ? cmdView :
                         paramSel ? (paramReg & `LIGHT_PARAM_RW_MASK) :
                         resHiSel ? lightResult[15:8] :
                         resLoSel ? lightResult[7:0] :
                         8'h00;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            paramReg <= `LIGHT_PARAM_RESET;
        end else if (paramWrite) begin
            paramReg <= regWrData & `LIGHT_PARAM_RW_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdData <= 8'h00;
        end else begin
            regRdData <= next_rdData;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // measurement sequencer

    // settings are frozen at start so a write mid-cycle cannot skew the mean
    logic runOffs;
    logic [AVG_W-1:0] runAvg;
    logic [CNT_W-1:0] convCnt;
    logic [SAMPLE_W-1:0] offsetVal;
    logic [SAMPLE_W-1:0] avgMean;

    wire [CNT_W-1:0] next_convCnt = convCnt + CNT_W'(1);
    wire lastConv = (next_convCnt == convCount(runAvg));
    wire sampleTaken = (state == ambient_light_pkg::ST_LIGHT_WAIT) && convDone;
    wire [SAMPLE_W-1:0] corrected = offsetCorrect(convData, offsetVal, runOffs);

    assign convStart = (state == ambient_light_pkg::ST_OFFS_START) ||
                       (state == ambient_light_pkg::ST_LIGHT_START);
    assign convOffset = (state == ambient_light_pkg::ST_OFFS_START);

    always_comb begin
        case (state)
            ambient_light_pkg::ST_IDLE: begin
                if (!startReq) begin
                    next_state = ambient_light_pkg::ST_IDLE;
                end else if (paramReg[`LIGHT_OFFS_BIT]) begin
                    next_state = ambient_light_pkg::ST_OFFS_START;
                end else begin
                    next_state = ambient_light_pkg::ST_LIGHT_START;
                end
            end
            ambient_light_pkg::ST_OFFS_START: next_state = ambient_light_pkg::ST_OFFS_WAIT;
            ambient_light_pkg::ST_OFFS_WAIT: begin
                next_state = convDone ? ambient_light_pkg::ST_LIGHT_START :
                                        ambient_light_pkg::ST_OFFS_WAIT;
            end
            ambient_light_pkg::ST_LIGHT_START: next_state = ambient_light_pkg::ST_LIGHT_WAIT;
            ambient_light_pkg::ST_LIGHT_WAIT: begin
                if (!convDone) begin
                    next_state = ambient_light_pkg::ST_LIGHT_WAIT;
                end else if (lastConv) begin
                    next_state = ambient_light_pkg::ST_FINISH;
                end else if (runOffs) begin
                    next_state = ambient_light_pkg::ST_OFFS_START;
                end else begin
                    next_state = ambient_light_pkg::ST_LIGHT_START;
                end
            end
            ambient_light_pkg::ST_FINISH: next_state = ambient_light_pkg::ST_IDLE;
            default: next_state = ambient_light_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= ambient_light_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            runOffs <= 1'b0;
            runAvg <= '0;
        end else if (startReq) begin
            runOffs <= paramReg[`LIGHT_OFFS_BIT];
            runAvg <= paramReg[`LIGHT_AVG_MSB:`LIGHT_AVG_LSB];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || startReq) begin
            convCnt <= '0;
        end else if (sampleTaken) begin
            convCnt <= next_convCnt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            offsetVal <= '0;
        end else if (state == ambient_light_pkg::ST_OFFS_WAIT && convDone) begin
            offsetVal <= convData;
        end
    end

    light_sample_averager #(
        .SAMPLE_W(SAMPLE_W),
        .SHIFT_W(AVG_W)
    ) u_averager (
        .clk(clk),
        .rst_n(rst_n),
        .clear(startReq),
        .addValid(sampleTaken),
        .sample(corrected),
        .shift(runAvg),
        .mean(avgMean)
    );

    // result and ready change together; ready falls only when a new run starts
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lightResult <= '0;
            lightDataReady <= 1'b0;
        end else if (state == ambient_light_pkg::ST_FINISH) begin
            lightResult <= avgMean;
            lightDataReady <= 1'b1;
        end else if (startReq) begin
            lightDataReady <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    property p_param_write;
        @(posedge clk) disable iff (!rst_n)
        paramWrite |=> paramReg == ($past(regWrData) & `LIGHT_PARAM_RW_MASK);
    endproperty
    a_param_write: assert property (p_param_write)
        else $error("parameter register did not take the write");

    property p_cont_restart;
        @(posedge clk) disable iff (!rst_n)
        idle && contMode |=> !idle;
    endproperty
    a_cont_restart: assert property (p_cont_restart)
        else $error("continuous mode did not restart a measurement");

    property p_reset_value;
        @(posedge clk) disable iff (!rst_n)
        $past(!rst_n) |-> paramReg == `LIGHT_PARAM_RESET;
    endproperty
    a_reset_value: assert property (p_reset_value)
        else $error("parameter register reset value wrong");

    property p_offset_first;
        @(posedge clk) disable iff (!rst_n)
        state == ambient_light_pkg::ST_LIGHT_START && runOffs |->
            $past(state) == ambient_light_pkg::ST_OFFS_WAIT;
    endproperty
    a_offset_first: assert property (p_offset_first)
        else $error("light conversion without a preceding offset conversion");

    property p_conv_count;
        @(posedge clk) disable iff (!rst_n)
        state == ambient_light_pkg::ST_FINISH |-> convCnt == convCount(runAvg);
    endproperty
    a_conv_count: assert property (p_conv_count)
        else $error("wrong number of conversions in the cycle");

    property p_mean_stored;
        @(posedge clk) disable iff (!rst_n)
        state == ambient_light_pkg::ST_FINISH |=> lightResult == $past(avgMean) && lightDataReady;
    endproperty
    a_mean_stored: assert property (p_mean_stored)
        else $error("mean not stored at end of cycle");

    property p_trigger_start;
        @(posedge clk) disable iff (!rst_n)
        idle && lightSingleShotTrigger |=> convStart ##1 !idle;
    endproperty
    a_trigger_start: assert property (p_trigger_start)
        else $error("trigger did not start a conversion");

    property p_result_bytes;
        @(posedge clk) disable iff (!rst_n)
        regRead && resHiSel |=> regRdData == $past(lightResult[15:8]);
    endproperty
    a_result_bytes: assert property (p_result_bytes)
        else $error("result high byte read wrong");

    property p_unused_zero;
        @(posedge clk) disable iff (!rst_n)
        regRead && paramSel |=> regRdData[6:4] == 3'b000;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused parameter bits read nonzero");

endmodule

// [include/ambient_light_cfg.svh]
`ifndef AMBIENT_LIGHT_CFG_SVH
`define AMBIENT_LIGHT_CFG_SVH

// register addresses
`define LIGHT_CMD_ADDR 8'h80
`define LIGHT_PARAM_ADDR 8'h84
`define LIGHT_RES_HI_ADDR 8'h85
`define LIGHT_RES_LO_ADDR 8'h86

// command register fields
`define LIGHT_TRIG_BIT 4
`define LIGHT_READY_BIT 6

// parameter register fields
`define LIGHT_CONT_BIT 7
`define LIGHT_OFFS_BIT 3
`define LIGHT_AVG_MSB 2
`define LIGHT_AVG_LSB 0

// continuous off, offset compensation on, averaging 2^5 = 32
`define LIGHT_PARAM_RESET 8'h0D
// bits 6..4 are not implemented
`define LIGHT_PARAM_RW_MASK 8'h8F

`endif

// [include/ambient_light_pkg.sv]
package ambient_light_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_OFFS_START = 3'b001,
        ST_OFFS_WAIT = 3'b010,
        ST_LIGHT_START = 3'b011,
        ST_LIGHT_WAIT = 3'b100,
        ST_FINISH = 3'b101
    } light_state_t;

    typedef logic [15:0] light_sample_t;

endpackage

// [hdl/light_sample_averager.sv]
module light_sample_averager #(
    parameter int SAMPLE_W = 16,
    parameter int SHIFT_W = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // accumulate
    input wire logic clear,
    input wire logic addValid,
    input wire logic [SAMPLE_W-1:0] sample,
    // mean
    input wire logic [SHIFT_W-1:0] shift,
    output logic [SAMPLE_W-1:0] mean
);

    // wide enough that 2^(2^SHIFT_W - 1) full-scale samples never overflow
    localparam int ACC_W = SAMPLE_W + (1 << SHIFT_W) - 1;

    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] next_acc;
    logic [ACC_W-1:0] shifted;

    assign next_acc = clear ? '0 : (addValid ? acc + ACC_W'(sample) : acc);
    // power-of-two count, so the division is a plain shift
    assign shifted = acc >> shift;
    assign mean = shifted[SAMPLE_W-1:0];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc <= '0;
        end else begin
            acc <= next_acc;
        end
    end

endmodule

// [tb/light_conv_model.sv]
module light_conv_model (
    // clock
    input wire logic clk,
    // converter link
    input wire logic convStart,
    input wire logic convOffset,
    output logic convDone,
    output logic [15:0] convData
);
    timeunit 1ns;
    timeprecision 1ps;
    int seed = 69415;
    int slow = 0;
    int cnt = -1;
    int offCnt = 0;
    int rawQ[$];
    int offQ[$];
    logic isOff = 1'b0;
    logic fire = 1'b0;
    logic [15:0] lastOff = 16'h0000;
    logic [15:0] val;

    initial begin
        convDone = 1'b0;
        convData = 16'h0000;
    end

    // a start seen on the same edge as an answer would be lost, so the
    // earliest answer lands one full cycle after the start
    always @(negedge clk) begin
        fire = 1'b0;
        if (convStart) begin
            cnt = slow ? ($random(seed) & 3) : 0;
            isOff = convOffset;
        end else if (cnt == 0) begin
            cnt = -1;
            fire = 1'b1;
            val = $random(seed);
            if (isOff) begin
                lastOff = val & 16'h00ff;
                offCnt++;
                val = lastOff;
            end else begin
                // small range so compensation sometimes clamps at zero
                val = val & 16'h01ff;
                rawQ.push_back(val);
                offQ.push_back(lastOff);
            end
        end else if (cnt > 0) begin
            cnt--;
        end
        // one update per edge for each output
        convDone <= fire;
        // idle data keeps toggling so a stale value never looks valid
        convData <= fire ? val : ~convData;
    end
endmodule

// [tb/tb_ambient_light_measure_config.sv]
module tb_ambient_light_measure_config;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regRdData;
    logic convStart;
    logic convOffset;
    logic convDone;
    logic [15:0] convData;
    logic [7:0] rv;
    logic [7:0] hi;
    logic comp;
    int fails = 0;
    int checks_done = 0;
    int sum;
    int v;

    always #5 clk = ~clk;

    ambient_light_measure_config dut_u (
        .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .convStart(convStart), .convOffset(convOffset), .convDone(convDone),
        .convData(convData)
    );

    light_conv_model conv_u (
        .clk(clk), .convStart(convStart), .convOffset(convOffset),
        .convDone(convDone), .convData(convData)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // each access opens on a fresh falling edge so strobes never toggle twice
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(negedge clk);
        regWrite = 1'b0;
    endtask

    task automatic rd(logic [7:0] a);
        @(negedge clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clk);
        regRead = 1'b0;
        rv = regRdData;
    endtask

    task automatic waitIdle();
        for (int i = 0; i < 4000; i++) begin
            rd(8'h80);
            if (rv[4] === 1'b0)
                return;
        end
        fails++;
        $display("MISMATCH busy expected 0 seen 1");
        results();
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        rd(8'h84);
        check("param reset", rv, 16'h000D);
        rd(8'h85);
        check("result hi reset", rv, 16'h0000);
        // bit 7 kept clear: continuous mode would start a long run here
        wr(8'h84, 8'h7F);
        rd(8'h84);
        check("param unused bits", rv, 16'h000F);
        rd(8'h83);
        check("unmapped read", rv, 16'h0000);
        for (int a = 0; a < 8; a++) begin
            comp = a[0];
            conv_u.slow = a[1];
            wr(8'h84, {4'h0, comp, a[2:0]});
            rd(8'h84);
            check("param echo", rv, {4'h0, comp, a[2:0]});
            conv_u.rawQ.delete();
            conv_u.offQ.delete();
            conv_u.offCnt = 0;
            wr(8'h80, 8'h10);
            rd(8'h80);
            check("busy after trigger", rv, 16'h0010);
            waitIdle();
            check("ready", rv, 16'h0040);
            sum = 0;
            for (int i = 0; i < conv_u.rawQ.size(); i++) begin
                v = comp ? conv_u.rawQ[i] - conv_u.offQ[i] : conv_u.rawQ[i];
                sum += (v < 0) ? 0 : v;
            end
            rd(8'h85);
            hi = rv;
            rd(8'h86);
            check("mean", {hi, rv}, sum >> a);
            check("conversions", conv_u.rawQ.size(), 1 << a);
            check("offsets", conv_u.offCnt, comp ? (1 << a) : 0);
        end
        // continuous mode keeps restarting without any trigger write
        conv_u.rawQ.delete();
        wr(8'h84, 8'h80);
        rd(8'h84);
        check("param cont", rv, 16'h0080);
        repeat (60) @(negedge clk);
        wr(8'h84, 8'h00);
        waitIdle();
        check("continuous runs", conv_u.rawQ.size() > 3, 16'h0001);
        check("continuous ready", rv, 16'h0040);
        rd(8'h85);
        hi = rv;
        rd(8'h86);
        check("continuous mean", {hi, rv}, conv_u.rawQ[$]);
        rd(8'h84);
        check("param cleared", rv, 16'h0000);
        results();
    end
endmodule
